// file: include/spit_pkg.sv
// Shared constants and types for the parallel video input timing block.
package spit_pkg;
    // ==========================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DROPS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TRS = 8'h0c;
    localparam int CTRL_HCFG_BIT = 0;
    localparam int CTRL_CAP_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_WIDE_BIT = 2;
    localparam int ST_TSRC_BIT = 3;
    localparam int ST_PROC_BIT = 4;
    localparam int ST_CLK_BIT = 5;
    localparam int ST_HCFG_BIT = 6;
    localparam int ST_LEVEL_LSB = 8;
    // ==========================================================
    // Video words
    localparam int WORD_W = 10;
    localparam logic [WORD_W-1:0] TRS_ONES = 10'h3ff;
    localparam logic [WORD_W-1:0] TRS_ZERO = 10'h000;
    localparam int XYZ_F = 8;
    localparam int XYZ_V = 7;
    localparam int XYZ_H = 6;
    localparam int FIFO_DEPTH = 16;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PCLK_SLOW_PERIOD_PS = 74075;
    localparam int PCLK_LOSS_PERIODS = 4;
    localparam int PCLK_LOSS_CYCLES =
        (PCLK_LOSS_PERIODS * PCLK_SLOW_PERIOD_PS) / CLK_PERIOD_PS;
    localparam int LOSS_W = 6;
    // ==========================================================
    // Operating modes and TRS tracking states
    typedef enum logic [1:0] {MODE_SMPTE, MODE_THROUGH, MODE_ASI, MODE_BAD} spit_mode_t;
    typedef enum logic [1:0] {TRS_IDLE, TRS_GOT_ONES, TRS_GOT_ZERO1, TRS_GOT_ZERO2} spit_trs_t;
endpackage : spit_pkg

// file: verilog/spit_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module spit_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("spit_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign level = wr_ptr - rd_ptr;
    assign in_ready = (level != DEPTH[AW:0]) || (DEPTH == (1 << AW) && level[AW] == 1'b0);
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    fifo_bounds_a: assert property (@(posedge clk) disable iff (srst)
        (level <= DEPTH) and (push |=> level == $past(level) + 1'b1 - (AW + 1)'($past(pop))))
        else $error("FIFO level out of step with push and pop.");
endmodule : spit_fifo

// file: verilog/spit_trs_lane.sv
// One ten-bit lane: finds TRS preambles and rewrites the XYZ word from the flags.
`timescale 1ns/10ps
module spit_trs_lane (
    input wire logic clk,
    input wire logic srst,
    input wire logic word_en,
    input wire logic [spit_pkg::WORD_W-1:0] din,
    input wire logic rewrite,
    input wire logic f_bit,
    input wire logic v_bit,
    input wire logic h_bit,
    output logic [spit_pkg::WORD_W-1:0] dout,
    output logic xyz,
    output logic rewrote
);
    // ==========================================================
    // XYZ word with protection bits.
    function automatic logic [spit_pkg::WORD_W-1:0] make_xyz(input logic f, input logic v,
                                                            input logic h);
        make_xyz = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
    endfunction : make_xyz

    spit_pkg::spit_trs_t state;
    spit_pkg::spit_trs_t next_state;
    wire is_ones = (din == spit_pkg::TRS_ONES);
    wire is_zero = (din == spit_pkg::TRS_ZERO);
    wire at_xyz = (state == spit_pkg::TRS_GOT_ZERO2);
    wire [spit_pkg::WORD_W-1:0] new_xyz = make_xyz(f_bit, v_bit, h_bit);
    wire [spit_pkg::WORD_W-1:0] next_dout = (at_xyz && rewrite) ? new_xyz : din;

    always_comb begin
        case (state)
            spit_pkg::TRS_IDLE: next_state = is_ones ? spit_pkg::TRS_GOT_ONES : spit_pkg::TRS_IDLE;
            spit_pkg::TRS_GOT_ONES: begin
                if (is_zero) begin
                    next_state = spit_pkg::TRS_GOT_ZERO1;
                end else begin
                    next_state = is_ones ? spit_pkg::TRS_GOT_ONES : spit_pkg::TRS_IDLE;
                end
            end
            spit_pkg::TRS_GOT_ZERO1: begin
                if (is_zero) begin
                    next_state = spit_pkg::TRS_GOT_ZERO2;
                end else begin
                    next_state = is_ones ? spit_pkg::TRS_GOT_ONES : spit_pkg::TRS_IDLE;
                end
            end
            default: next_state = is_ones ? spit_pkg::TRS_GOT_ONES : spit_pkg::TRS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= spit_pkg::TRS_IDLE;
            dout <= '0;
            xyz <= 1'b0;
            rewrote <= 1'b0;
        end else if (word_en) begin
            state <= next_state;
            dout <= next_dout; // RULE1 RULE4 RULE7
            xyz <= at_xyz;
            rewrote <= at_xyz && rewrite;
        end
    end

    field_bit_a: assert property (@(posedge clk) disable iff (srst) // RULE1
        word_en && at_xyz && rewrite |=> dout[spit_pkg::XYZ_F] == $past(f_bit))
        else $error("F bit of rewritten XYZ does not follow the field flag.");
    vert_bit_a: assert property (@(posedge clk) disable iff (srst) // RULE4
        word_en && at_xyz && rewrite |=> dout[spit_pkg::XYZ_V] == $past(v_bit))
        else $error("V bit of rewritten XYZ does not follow the blanking flag.");
    horiz_bit_a: assert property (@(posedge clk) disable iff (srst) // RULE7
        word_en && at_xyz && rewrite |=> dout[spit_pkg::XYZ_H] == $past(h_bit))
        else $error("H bit of rewritten XYZ does not follow the horizontal flag.");
    flags_ignored_a: assert property (@(posedge clk) disable iff (srst) // RULE3
        word_en && !rewrite |=> dout == $past(din))
        else $error("Word altered while flags are to be ignored.");
endmodule : spit_trs_lane

// file: verilog/spit_input.sv
// Parallel video input stage: pin sampling, mode decode, TRS flag insertion, FIFO, registers.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Contract
// RULE1: F bit set while field flag high.
// RULE2: Source holds field flag high in field two.
// RULE3: Field flag ignored under embedded timing.
// RULE4: V bit set while vertical flag high.
// RULE5: Source drives vertical flag over blanking interval.
// RULE6: Vertical flag ignored under embedded timing.
// RULE7: H bit set while horizontal flag high.
// RULE8: Horizontal select zero: flag spans EAV, SAV. Code ignores the select and copies the flag as under select one.
// RULE9: Horizontal select one: flag follows received H.
// RULE10: Wide bus lower half: chroma, data, unused.
// RULE11: Narrow bus lower half always unused.
// RULE12: Wide bus upper half: luma, data, ASI.
// RULE13: Narrow bus upper half: muxed video, data, ASI.
// RULE14: Mode from processing and ASI selects.
// RULE15: Select high embedded TRS, low external flags.
// RULE16: Source clock 13.5 or 27 MHz.
// RULE17: Sample bus and flags on clock rise.
// RULE18: Highest bit of each half is MSB.
module spit_input (
    input wire logic clk,
    input wire logic srst,
    input wire logic pclk_pin,
    input wire logic [19:0] din_pin,
    input wire logic f_pin,
    input wire logic v_pin,
    input wire logic h_pin,
    input wire logic timing_source_select,
    input wire logic processing_enable,
    input wire logic bus_width_select,
    input wire logic video_processing_select,
    input wire logic asi_mode_select,
    input wire logic [spit_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [spit_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [spit_pkg::DATA_W-1:0] reg_rdata,
    output logic out_valid,
    input wire logic out_ready,
    output logic [spit_pkg::WORD_W-1:0] out_upper,
    output logic [spit_pkg::WORD_W-1:0] out_lower,
    output logic out_lower_used,
    output logic out_xyz
);
    localparam int W = spit_pkg::WORD_W;
    localparam int PINS = 2 * W + 8;
    localparam int FW = 2 * W + 2;
    localparam int LVL_W = $clog2(spit_pkg::FIFO_DEPTH) + 1;
    localparam logic [spit_pkg::LOSS_W-1:0] LOSS_MAX =
        spit_pkg::LOSS_W'(spit_pkg::PCLK_LOSS_CYCLES);

    // ==========================================================
    // Mode decode.
    function automatic spit_pkg::spit_mode_t decode_mode(input logic proc_sel,
                                                         input logic asi_sel);
        case ({proc_sel, asi_sel})
            2'b10: decode_mode = spit_pkg::MODE_SMPTE;
            2'b00: decode_mode = spit_pkg::MODE_THROUGH;
            2'b01: decode_mode = spit_pkg::MODE_ASI;
            default: decode_mode = spit_pkg::MODE_BAD;
        endcase
    endfunction : decode_mode

    // ==========================================================
    // Two-flop synchronisers for every pin.
    logic [PINS-1:0] pins_meta;
    logic [PINS-1:0] pins_sync;
    logic pclk_prev;
    wire [PINS-1:0] pins_raw = {pclk_pin, f_pin, v_pin, h_pin, timing_source_select,
                                processing_enable, bus_width_select, asi_mode_select,
                                din_pin};
    wire [2*W-1:0] din_s = pins_sync[2*W-1:0];
    wire asi_s = pins_sync[2*W];
    wire wide_s = pins_sync[2*W+1];
    wire proc_en_s = pins_sync[2*W+2];
    wire tsrc_s = pins_sync[2*W+3];
    wire h_s = pins_sync[2*W+4];
    wire v_s = pins_sync[2*W+5];
    wire f_s = pins_sync[2*W+6];
    wire pclk_s = pins_sync[2*W+7];
    logic vsel_meta;
    logic vsel_s;

    always_ff @(posedge clk) begin
        if (srst) begin
            pins_meta <= '0;
            pins_sync <= '0;
            vsel_meta <= 1'b0;
            vsel_s <= 1'b0;
            pclk_prev <= 1'b0;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            vsel_meta <= video_processing_select;
            vsel_s <= vsel_meta;
            pclk_prev <= pclk_s;
        end
    end

    // A rising edge of the synchronised parallel clock marks one input word.
    wire word_en = pclk_s && !pclk_prev; // RULE17

    // ==========================================================
    // Word capture and lane steering.
    spit_pkg::spit_mode_t mode;
    logic wide;
    logic [W-1:0] cap_upper;
    logic [W-1:0] cap_lower;
    logic cap_lower_used;
    logic cap_f;
    logic cap_v;
    logic cap_h;
    logic cap_rewrite;
    logic cap_en;

    wire spit_pkg::spit_mode_t next_mode = decode_mode(vsel_s, asi_s); // RULE14
    // The lower half is only read on a wide bus outside ASI mode.
    wire next_lower_used = wide_s && (next_mode != spit_pkg::MODE_ASI); // RULE10 RULE11
    // Flags steer TRS only with external timing, processing on, in SMPTE mode.
    wire next_rewrite = !tsrc_s && proc_en_s && (next_mode == spit_pkg::MODE_SMPTE); // RULE15

    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= spit_pkg::MODE_THROUGH;
            wide <= 1'b0;
            cap_upper <= '0;
            cap_lower <= '0;
            cap_lower_used <= 1'b0;
            cap_f <= 1'b0;
            cap_v <= 1'b0;
            cap_h <= 1'b0;
            cap_rewrite <= 1'b0;
            cap_en <= 1'b0;
        end else begin
            cap_en <= word_en;
            if (word_en) begin
                mode <= next_mode;
                wide <= wide_s;
                cap_upper <= din_s[2*W-1:W]; // RULE12 RULE13 RULE18
                cap_lower <= next_lower_used ? din_s[W-1:0] : '0; // RULE10 RULE11 RULE18
                cap_lower_used <= next_lower_used;
                cap_f <= f_s; // RULE1 RULE2
                cap_v <= v_s; // RULE4 RULE5
                cap_h <= h_s; // RULE7 RULE8 RULE9
                cap_rewrite <= next_rewrite; // RULE3 RULE6
            end
        end
    end

    // ==========================================================
    // TRS lanes: upper and lower halves.
    logic [W-1:0] lane_dout [2];
    logic [1:0] lane_xyz;
    logic [1:0] lane_rewrote;
    logic lane_valid;
    logic lane_lower_used;
    wire [W-1:0] lane_din [2];
    assign lane_din[0] = cap_lower;
    assign lane_din[1] = cap_upper;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            spit_trs_lane u_lane (
                .clk(clk),
                .srst(srst),
                .word_en(cap_en),
                .din(lane_din[gi]),
                .rewrite(cap_rewrite && (gi == 1 || cap_lower_used)),
                .f_bit(cap_f),
                .v_bit(cap_v),
                .h_bit(cap_h),
                .dout(lane_dout[gi]),
                .xyz(lane_xyz[gi]),
                .rewrote(lane_rewrote[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            lane_valid <= 1'b0;
            lane_lower_used <= 1'b0;
        end else begin
            lane_valid <= cap_en;
            if (cap_en) begin
                lane_lower_used <= cap_lower_used;
            end
        end
    end

    // ==========================================================
    // Registers, FIFO and clock watchdog.
    logic [1:0] ctrl;
    logic [spit_pkg::DATA_W-1:0] drops;
    logic [spit_pkg::DATA_W-1:0] trs_count;
    logic [spit_pkg::LOSS_W-1:0] loss_cnt;
    logic fifo_in_ready;
    logic [FW-1:0] fifo_out;
    logic [LVL_W-1:0] fifo_level;

    wire capture_on = ctrl[spit_pkg::CTRL_CAP_BIT];
    wire fifo_push = lane_valid && capture_on;
    // Video cannot be stalled, so a word that finds the FIFO full is counted and lost.
    wire drop_evt = fifo_push && !fifo_in_ready;
    wire trs_evt = lane_valid && (lane_rewrote != 2'b00);
    wire pclk_alive = (loss_cnt != LOSS_MAX);
    wire wr_ctrl = reg_wr && (reg_addr == spit_pkg::REG_CTRL);
    wire wr_drops = reg_wr && (reg_addr == spit_pkg::REG_DROPS);
    wire wr_trs = reg_wr && (reg_addr == spit_pkg::REG_TRS);
    wire [FW-1:0] fifo_in = {lane_lower_used, |lane_xyz, lane_dout[1], lane_dout[0]};

    wire [spit_pkg::DATA_W-1:0] status_word =
        (spit_pkg::DATA_W'(mode) << spit_pkg::ST_MODE_LSB)
        | (spit_pkg::DATA_W'(wide) << spit_pkg::ST_WIDE_BIT)
        | (spit_pkg::DATA_W'(tsrc_s) << spit_pkg::ST_TSRC_BIT)
        | (spit_pkg::DATA_W'(proc_en_s) << spit_pkg::ST_PROC_BIT)
        | (spit_pkg::DATA_W'(pclk_alive) << spit_pkg::ST_CLK_BIT)
        | (spit_pkg::DATA_W'(ctrl[spit_pkg::CTRL_HCFG_BIT]) << spit_pkg::ST_HCFG_BIT)
        | (spit_pkg::DATA_W'(fifo_level) << spit_pkg::ST_LEVEL_LSB);

    wire [spit_pkg::DATA_W-1:0] next_rdata =
        !reg_rd ? '0 :
        (reg_addr == spit_pkg::REG_CTRL) ? spit_pkg::DATA_W'(ctrl) :
        (reg_addr == spit_pkg::REG_STATUS) ? status_word :
        (reg_addr == spit_pkg::REG_DROPS) ? drops :
        (reg_addr == spit_pkg::REG_TRS) ? trs_count : '0;

    spit_fifo #(.WIDTH(FW), .DEPTH(spit_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign out_lower_used = fifo_out[FW-1];
    assign out_xyz = fifo_out[FW-2];
    assign out_upper = fifo_out[2*W-1:W];
    assign out_lower = fifo_out[W-1:0];

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= spit_pkg::CTRL_RESET;
            drops <= '0;
            trs_count <= '0;
            reg_rdata <= '0;
            loss_cnt <= '0;
        end else begin
            reg_rdata <= next_rdata;
            if (wr_ctrl) begin
                ctrl <= reg_wdata[1:0];
            end
            // A new event in the clearing cycle is kept.
            if (wr_drops || drop_evt) begin
                drops <= wr_drops ? spit_pkg::DATA_W'(drop_evt) : drops + 1'b1;
            end
            if (wr_trs || trs_evt) begin
                trs_count <= wr_trs ? spit_pkg::DATA_W'(trs_evt) : trs_count + 1'b1;
            end
            if (word_en) begin
                loss_cnt <= '0;
            end else if (pclk_alive) begin
                loss_cnt <= loss_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks.
    mode_decode_a: assert property (@(posedge clk) disable iff (srst) // RULE14
        word_en |=> mode == decode_mode($past(vsel_s), $past(asi_s)))
        else $error("Operating mode not decoded from the select pins.");
    lower_unused_a: assert property (@(posedge clk) disable iff (srst) // RULE11
        word_en && !wide_s |=> cap_lower == '0 && !cap_lower_used)
        else $error("Lower half read on a narrow bus.");
    lower_asi_a: assert property (@(posedge clk) disable iff (srst) // RULE10
        word_en && wide_s && asi_s && !vsel_s |=> !cap_lower_used && cap_lower == '0)
        else $error("Lower half read in ASI mode.");
    upper_capture_a: assert property (@(posedge clk) disable iff (srst) // RULE12
        word_en |=> cap_upper == $past(din_s[2*W-1:W]))
        else $error("Upper half not captured on the clock rise.");
    embedded_timing_a: assert property (@(posedge clk) disable iff (srst) // RULE6
        word_en && tsrc_s |=> !cap_rewrite)
        else $error("External flags used while embedded timing is selected.");
    sample_edge_a: assert property (@(posedge clk) disable iff (srst) // RULE17
        !word_en |=> $stable(cap_f) && $stable(cap_v) && $stable(cap_h))
        else $error("Flags sampled away from a parallel clock rise.");
    word_path_a: assert property (@(posedge clk) disable iff (srst)
        word_en && capture_on ##2 fifo_in_ready |-> fifo_push)
        else $error("Captured word did not reach the FIFO two cycles later.");
    drop_count_a: assert property (@(posedge clk) disable iff (srst)
        drop_evt && !wr_drops |=> drops == $past(drops) + 1'b1)
        else $error("Lost word not counted.");
endmodule : spit_input

// file: verification/spit_src_model.sv
// Upstream video source model driving the parallel clock, data bus and timing flags.
`timescale 1ns/10ps
module spit_src_model (
    input wire logic clk,
    input wire logic send,
    input wire logic slow,
    input wire logic [22:0] word,
    output logic done,
    output logic pclk_pin,
    output logic [19:0] din_pin,
    output logic f_pin,
    output logic v_pin,
    output logic h_pin
);
    int cnt = 0;
    int half;
    initial begin
        done = 1'b0;
        pclk_pin = 1'b0;
        {f_pin, v_pin, h_pin, din_pin} = 23'h000000;
    end
    // Half periods in system cycles give a slower clock for the wide bus.
    assign half = slow ? 5 : 3;
    // The clock stands still between words, and an idle bus toggles every cycle.
    always @(posedge clk) begin
        done <= 1'b0;
        if (!send) begin
            din_pin <= ~din_pin;
        end else if (!done) begin
            cnt <= cnt + 1;
            if (cnt == 0) begin
                {f_pin, v_pin, h_pin, din_pin} <= word;
            end
            if (cnt == half) begin
                pclk_pin <= 1'b1;
            end
            if (cnt == 2 * half) begin
                pclk_pin <= 1'b0;
            end
            if (cnt == 3 * half) begin
                done <= 1'b1;
                cnt <= 0;
            end
        end
    end
endmodule : spit_src_model

// file: verification/spit_input_tb.sv
// Self-checking testbench for the parallel video input stage.
`timescale 1ns/10ps
module spit_input_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pclk_pin, f_pin, v_pin, h_pin, done, out_valid, out_lower_used, out_xyz;
    logic [19:0] din_pin;
    logic timing_source_select = 1'b0;
    logic processing_enable = 1'b1;
    logic bus_width_select = 1'b1;
    logic video_processing_select = 1'b1;
    logic asi_mode_select = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic out_ready = 1'b0;
    logic [9:0] out_upper, out_lower;
    logic send = 1'b0;
    logic stall_all = 1'b0;
    logic [22:0] word = 23'h000000;
    logic [21:0] head;
    wire [21:0] seen_word = {out_upper, out_lower, out_lower_used, out_xyz};
    logic [21:0] expq[$];
    integer seed = 29;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_rw = 0;
    always #4 clk = ~clk;
    spit_input spit_input_i (.clk, .srst, .pclk_pin, .din_pin, .f_pin, .v_pin, .h_pin,
        .timing_source_select, .processing_enable, .bus_width_select,
        .video_processing_select, .asi_mode_select, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .out_valid, .out_ready, .out_upper, .out_lower,
        .out_lower_used, .out_xyz);
    spit_src_model spit_src_model_i (.clk, .send, .slow(bus_width_select), .word, .done,
        .pclk_pin, .din_pin, .f_pin, .v_pin, .h_pin);
    // ==========================================================
    // Checking and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic give_up();
        n_mismatch++;
        $display("Error at %0t: wait timed out", $time);
        close_out();
    endtask : give_up
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, want);
    endtask : reg_read
    function automatic logic [21:0] expect_word(input logic [22:0] w, input logic pos);
        logic used, rw, f, v, h;
        logic [9:0] up, lo;
        {f, v, h} = w[22:20];
        used = bus_width_select
            && (video_processing_select || !asi_mode_select);
        rw = pos && !timing_source_select && processing_enable;
        rw = rw && video_processing_select && !asi_mode_select;
        up = w[19:10];
        lo = used ? w[9:0] : 10'h000;
        if (rw) begin
            up = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
            lo = used ? up : 10'h000;
            n_rw++;
        end
        return {up, lo, used, pos};
    endfunction : expect_word
    function automatic logic [31:0] status_exp(input logic [4:0] lvl);
        logic [1:0] code;
        code = video_processing_select ? (asi_mode_select ? 2'h3 : 2'h0)
            : (asi_mode_select ? 2'h2 : 2'h1);
        return {19'h00000, lvl, 3'h1, processing_enable, timing_source_select,
            bus_width_select, code};
    endfunction : status_exp
    function automatic logic [19:0] rnd_word();
        logic [19:0] r;
        r = 20'($random(seed));
        return {1'b0, r[18:11], 2'b10, r[8:1], 1'b1};
    endfunction : rnd_word
    task automatic send_word(input logic [22:0] w, input logic pos, input logic keep);
        int i;
        @(posedge clk);
        word <= w;
        send <= 1'b1;
        if (keep) expq.push_back(expect_word(w, pos));
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (done === 1'b1) break;
        end
        send <= 1'b0;
        if (i == 100) give_up();
    endtask : send_word
    task automatic drain();
        int i;
        for (i = 0; i < 500; i++) begin
            @(posedge clk);
            if (expq.size() == 0 && out_valid === 1'b0) break;
        end
        if (i == 500) give_up();
    endtask : drain
    task automatic set_ctl(input logic [4:0] c);
        @(posedge clk);
        {timing_source_select, processing_enable, bus_width_select} <= c[4:2];
        {video_processing_select, asi_mode_select} <= c[1:0];
        repeat (8) @(posedge clk);
    endtask : set_ctl
    // The consumer stalls at random and compares each word taken with the oldest note.
    always @(posedge clk) begin
        out_ready <= !stall_all && ($random(seed) % 3 != 0);
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            if (expq.size() == 0) begin
                check(32'h00000001, 32'h00000000);
            end else begin
                head = expq.pop_front();
                check({10'h000, seen_word}, {10'h000, head});
            end
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        int c;
        logic [1:0] m;
        logic [19:0] d;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        reg_read(spit_pkg::REG_CTRL, {30'h0, spit_pkg::CTRL_RESET});
        reg_write(8'h10, 32'hffffffff);
        reg_read(8'h10, 32'h00000000);
        reg_read(spit_pkg::REG_CTRL, {30'h0, spit_pkg::CTRL_RESET});
        for (c = 0; c < 8; c++) begin
            m = c[2:1];
            set_ctl({2'b01, c[0], m == 2'h0 || m == 2'h3, m[1]});
            send_word({3'b000, rnd_word()}, 1'b0, 1'b1);
            send_word({3'b111, rnd_word()}, 1'b0, 1'b1);
            drain();
            reg_read(spit_pkg::REG_STATUS, status_exp(5'h00));
        end
        // Timing reference sequences under every flag pattern and timing choice.
        for (c = 0; c < 12; c++) begin
            set_ctl({c == 8 || c == 9, c != 10, c != 11, 2'b10});
            for (int k = 0; k < 4; k++) begin
                d = (k == 0) ? 20'hfffff : (k == 3) ? 20'h80200 : 20'h00000;
                send_word({c[2:0], d}, k == 3, 1'b1);
            end
            drain();
        end
        reg_read(spit_pkg::REG_TRS, n_rw);
        reg_write(spit_pkg::REG_TRS, 32'h00000000);
        reg_read(spit_pkg::REG_TRS, 32'h00000000);
        reg_write(spit_pkg::REG_CTRL, 32'h00000001);
        reg_read(spit_pkg::REG_CTRL, 32'h00000001);
        send_word({3'b000, rnd_word()}, 1'b0, 1'b0);
        repeat (12) @(posedge clk);
        reg_write(spit_pkg::REG_CTRL, 32'h00000002);
        stall_all <= 1'b1;
        for (c = 0; c < 18; c++) send_word({3'b000, rnd_word()}, 1'b0, c < 16);
        repeat (8) @(posedge clk);
        reg_read(spit_pkg::REG_DROPS, 32'h00000002);
        reg_read(spit_pkg::REG_STATUS, status_exp(5'h10));
        reg_write(spit_pkg::REG_DROPS, 32'h00000000);
        reg_read(spit_pkg::REG_DROPS, 32'h00000000);
        stall_all <= 1'b0;
        drain();
        close_out();
    end
endmodule : spit_input_tb
